// ===== design/cob_sequencer.sv
/*
  Cache-op sequencer end with its receive FIFO: times primary instruction
  and secondary cache operations and collects fill data from the link.
  Assumes core inputs and the link run on mclk_in; the agent drives data.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cob_params.svh"

// ----------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------
module cob_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_in && !full;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule : cob_fifo

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
module cob_sequencer import cob_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // core operation port
  input wire logic op_valid_in,
  output logic op_ready_out,
  input wire logic op_secondary_in,
  input wire logic [2:0] op_code_in,
  input wire logic op_hit_in,
  input wire logic [1:0] op_start_dw_in,
  input wire logic op_subblock_in,
  output logic op_done_out,
  output logic cache_modify_out,
  output logic order_error_out,
  // pending work that outranks cache operations
  input wire logic miss_pending_in,
  input wire logic writeback_pending_in,
  input wire logic ext_req_pending_in,
  // configuration
  input wire logic [3:0] bus_clock_divisor_in,
  // fill write port
  output logic fill_wr_valid_out,
  input wire logic fill_wr_ready_in,
  output logic [1:0] fill_wr_index_out,
  output logic [63:0] fill_wr_data_out,
  // link
  cob_bus_if.seq bus
);

  // decode table for both caches; unused codes become one-cycle no-ops
  function automatic cob_op_plan_t cob_decode(input logic sec, input logic [2:0] code,
                                              input logic hit);
    cob_op_plan_t p;
    p = '{pre: 4'h0, sys_periods: 8'h00, post: `COB_CYC_NOP,
          use_sys: 1'b0, use_bus: 1'b0, modify: 1'b0};
    if (!sec) begin
      unique case (code)
        `COB_PI_INDEX_INV: begin
          p.post = `COB_CYC_INDEX_INV;
          p.modify = 1'b1;
        end
        `COB_PI_INDEX_LOAD: p.post = `COB_CYC_INDEX_LOAD;
        `COB_PI_INDEX_STORE: begin
          p.post = `COB_CYC_INDEX_STORE;
          p.modify = 1'b1;
        end
        `COB_PI_HIT_INV: begin
          p.post = hit ? `COB_CYC_HIT_INV_HIT : `COB_CYC_HIT_MISS;
          p.modify = hit;
        end
        `COB_PI_FILL: begin
          p.pre = `COB_FILL_PRE;
          p.post = `COB_FILL_POST;
          p.use_bus = 1'b1;
          p.modify = 1'b1;
        end
        `COB_PI_HIT_WB: begin
          p.post = hit ? `COB_CYC_HIT_WB_HIT : `COB_CYC_HIT_MISS;
        end
        default: ;
      endcase
    end else begin
      unique case (code)
        `COB_SC_FLASH_INV: p.sys_periods = `COB_SC_FLASH_PERIODS;
        `COB_SC_INDEX_LOAD: p.sys_periods = `COB_SC_LOAD_PERIODS;
        `COB_SC_INDEX_STORE: p.sys_periods = `COB_SC_STORE_PERIODS;
        `COB_SC_PAGE_INV: p.sys_periods = `COB_SC_PAGE_PERIODS;
        default: ;
      endcase
      if (p.sys_periods != 8'h00) begin
        p.pre = `COB_SC_PRE;
        p.post = `COB_SC_POST;
        p.use_sys = 1'b1;
        p.modify = (code != `COB_SC_INDEX_LOAD);
      end
    end
    return p;
  endfunction : cob_decode

  cob_seq_state_t state;
  cob_op_plan_t plan_q;
  logic [11:0] cnt;
  logic [3:0] div_cnt;
  logic [1:0] taken;
  logic [1:0] start_q;
  logic sub_q;

  // ----------------------------------------------------------------
  // divisor and bus clock phase
  // ----------------------------------------------------------------
  wire [3:0] div = (bus_clock_divisor_in < `COB_DIV_MIN) ? `COB_DIV_MIN :
                   (bus_clock_divisor_in > `COB_DIV_MAX) ? `COB_DIV_MAX :
                   bus_clock_divisor_in;
  wire sys_tick = (div_cnt >= div - 4'h1);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= sys_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // decode and handshakes
  // ----------------------------------------------------------------
  wire blocked = miss_pending_in || writeback_pending_in || ext_req_pending_in;
  wire cob_op_plan_t plan = cob_decode(op_secondary_in, op_code_in, op_hit_in);
  wire [11:0] sys_load = 12'(plan_q.sys_periods) * 12'(div);
  wire [1:0] fifo_idx;
  wire fifo_in_ready;
  wire dw_take = bus.dw_valid && fifo_in_ready;
  wire [1:0] expect_idx = cob_dw_index(start_q, taken, sub_q);

  assign op_ready_out = (state == seq_idle) && !blocked;
  wire op_fire = op_valid_in && op_ready_out;
  assign op_done_out = (state == seq_post) && (cnt == 12'h001);
  assign cache_modify_out = (state != seq_idle) && plan_q.modify;

  assign bus.sys_tick = sys_tick;
  assign bus.blk_req = (state == seq_bus);
  assign bus.blk_start_dw = start_q;
  assign bus.blk_subblock = sub_q;
  assign bus.dw_ready = fifo_in_ready;

  // the fifo decouples the link from a stalled fill write port
  cob_fifo #(
    .WIDTH(66),
    .DEPTH(`COB_FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .in_valid_in(bus.dw_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in({bus.doubleword_index, bus.dw_data}),
    .out_valid_out(fill_wr_valid_out),
    .out_ready_in(fill_wr_ready_in),
    .out_data_out({fifo_idx, fill_wr_data_out})
  );
  assign fill_wr_index_out = fifo_idx;

  // ----------------------------------------------------------------
  // phase machine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state <= seq_idle;
      plan_q <= '0;
      cnt <= 12'h000;
      taken <= 2'h0;
      start_q <= 2'h0;
      sub_q <= 1'b0;
    end else begin
      unique case (state)
        seq_idle: begin
          if (op_fire) begin
            plan_q <= plan;
            start_q <= op_start_dw_in;
            sub_q <= op_subblock_in;
            if (plan.pre != 4'h0) begin
              state <= seq_pre;
              cnt <= 12'(plan.pre);
            end else begin
              state <= seq_post;
              cnt <= 12'(plan.post);
            end
          end
        end
        seq_pre: begin
          if (cnt == 12'h001) begin
            state <= seq_align;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        seq_align: begin
          // waits 0..divisor-1 cycles for the bus clock edge
          if (sys_tick) begin
            taken <= 2'h0;
            cnt <= sys_load;
            state <= plan_q.use_bus ? seq_bus : seq_sys;
          end
        end
        seq_sys: begin
          if (cnt == 12'h001) begin
            state <= seq_post;
            cnt <= 12'(plan_q.post);
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        seq_bus: begin
          if (dw_take) begin
            taken <= taken + 2'h1;
            if (taken == `COB_BLOCK_LAST) begin
              state <= seq_post;
              cnt <= 12'(plan_q.post);
            end
          end
        end
        seq_post: begin
          if (cnt == 12'h001) begin
            state <= seq_idle;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        default: state <= seq_idle;
      endcase
    end
  end

  // sticky until reset so a misordered block is never missed
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      order_error_out <= 1'b0;
    end else if (dw_take && (state == seq_bus) && (bus.doubleword_index != expect_idx)) begin
      order_error_out <= 1'b1;
    end
  end

endmodule : cob_sequencer

`default_nettype wire

// ===== include/cob_params.svh
/*
  Timing counts and field constants for the cache-op sequencer and block link.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef COB_PARAMS_SVH
`define COB_PARAMS_SVH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define COB_PI_INDEX_INV     3'h0
`define COB_PI_INDEX_LOAD    3'h1
`define COB_PI_INDEX_STORE   3'h2
`define COB_PI_HIT_INV       3'h4
`define COB_PI_FILL          3'h5
`define COB_PI_HIT_WB        3'h6
`define COB_SC_FLASH_INV     3'h0
`define COB_SC_INDEX_LOAD    3'h1
`define COB_SC_INDEX_STORE   3'h2
`define COB_SC_PAGE_INV      3'h5

// ----------------------------------------------------------------
// cycle counts, processor cycles; secondary periods count bus clock periods
// ----------------------------------------------------------------
`define COB_CYC_INDEX_INV    5'h07
`define COB_CYC_INDEX_LOAD   5'h07
`define COB_CYC_INDEX_STORE  5'h08
`define COB_CYC_HIT_MISS     5'h07
`define COB_CYC_HIT_INV_HIT  5'h09
`define COB_CYC_HIT_WB_HIT   5'h14
`define COB_CYC_NOP          5'h01
// five, not six: taking the last word costs one cycle of its own
`define COB_FILL_PRE         4'h5
`define COB_FILL_POST        5'h03
`define COB_SC_PRE           4'h2
`define COB_SC_POST          5'h03
`define COB_SC_FLASH_PERIODS 8'h01
`define COB_SC_LOAD_PERIODS  8'h04
`define COB_SC_STORE_PERIODS 8'h01
`define COB_SC_PAGE_PERIODS  8'h80

// ----------------------------------------------------------------
// bus clock divisor, block geometry, agent latency
// ----------------------------------------------------------------
`define COB_DIV_MIN          4'h2
`define COB_DIV_MAX          4'h8
`define COB_BLOCK_LAST       2'h3
`define COB_DW_WIDTH         64
`define COB_FIFO_DEPTH       8
`define COB_ADDR_PHASE       9'h002
`define COB_ML_MIN           8'h03

`endif

// ===== include/cob_pkg.sv
/*
  Types shared by the sequencer end and the external agent end.
  Assumes cob_params.svh is available on the include path.
*/
`default_nettype none

package cob_pkg;

  typedef enum logic [2:0] {
    seq_idle  = 3'b000,
    seq_pre   = 3'b001,
    seq_align = 3'b010,
    seq_sys   = 3'b011,
    seq_bus   = 3'b100,
    seq_post  = 3'b101
  } cob_seq_state_t;

  typedef enum logic [1:0] {
    agt_idle = 2'b00,
    agt_wait = 2'b01,
    agt_data = 2'b10
  } cob_agent_state_t;

  typedef struct packed {
    logic [3:0] pre;
    logic [7:0] sys_periods;
    logic [4:0] post;
    logic use_sys;
    logic use_bus;
    logic modify;
  } cob_op_plan_t;

  // doubleword order: subblock xors start with the count, sequential is the count
  function automatic logic [1:0] cob_dw_index(input logic [1:0] start,
                                              input logic [1:0] count,
                                              input logic subblock);
    return subblock ? (start ^ count) : count;
  endfunction : cob_dw_index

endpackage : cob_pkg

`default_nettype wire

// ===== include/cob_bus_if.sv
/*
  Block-transfer link between the cache-op sequencer and the external agent.
  Assumes both ends run on the same clock; the testbench connects them.
*/
`timescale 1ns/1ns
`default_nettype none

interface cob_bus_if;
  logic sys_tick;
  logic blk_req;
  logic [1:0] blk_start_dw;
  logic blk_subblock;
  logic dw_valid;
  logic dw_ready;
  logic [1:0] doubleword_index;
  logic [63:0] dw_data;

  modport seq (
    output sys_tick, blk_req, blk_start_dw, blk_subblock, dw_ready,
    input dw_valid, doubleword_index, dw_data
  );

  modport agent (
    input sys_tick, blk_req, blk_start_dw, blk_subblock, dw_ready,
    output dw_valid, doubleword_index, dw_data
  );
endinterface : cob_bus_if

`default_nettype wire

// ===== design/cob_agent.sv
/*
  External agent end: answers a block request with four doublewords.
  Assumes the sequencer end drives sys_tick and blk_req on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cob_params.svh"

module cob_agent import cob_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // link
  cob_bus_if.agent bus,
  // memory side
  input wire logic [7:0] memory_latency_cycles_in,
  input wire logic [255:0] fill_line_in,
  output logic block_request_out,
  output logic [1:0] block_start_out
);

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  cob_agent_state_t state;
  logic [8:0] wait_cnt;
  logic [1:0] count;
  logic subblock;
  logic [255:0] line;
  logic dw_valid;
  logic [1:0] dw_idx;
  logic [63:0] dw_data;

  // latency below the minimum would outrun the secondary cache check
  wire [7:0] ml_eff = (memory_latency_cycles_in < `COB_ML_MIN) ?
                      `COB_ML_MIN : memory_latency_cycles_in;
  wire req_seen = (state == agt_idle) && bus.blk_req && bus.sys_tick;
  wire take = dw_valid && bus.dw_ready;
  wire [1:0] first_idx = cob_dw_index(block_start_out, 2'h0, subblock);
  wire [1:0] next_idx = cob_dw_index(block_start_out, count, subblock);

  assign bus.dw_valid = dw_valid;
  assign bus.doubleword_index = dw_idx;
  assign bus.dw_data = dw_data;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state <= agt_idle;
      wait_cnt <= 9'h000;
      count <= 2'h0;
      subblock <= 1'b0;
      line <= '0;
      dw_valid <= 1'b0;
      dw_idx <= 2'h0;
      dw_data <= 64'h0;
      block_request_out <= 1'b0;
      block_start_out <= 2'h0;
    end else begin
      block_request_out <= req_seen;
      unique case (state)
        agt_idle: begin
          if (req_seen) begin
            block_start_out <= bus.blk_start_dw;
            subblock <= bus.blk_subblock;
            line <= fill_line_in;
            wait_cnt <= `COB_ADDR_PHASE + {1'b0, ml_eff};
            state <= agt_wait;
          end
        end
        agt_wait: begin
          if (bus.sys_tick) begin
            if (wait_cnt == 9'h001) begin
              count <= 2'h0;
              dw_valid <= 1'b1;
              dw_idx <= first_idx;
              dw_data <= line[64*first_idx +: 64];
              state <= agt_data;
            end else begin
              wait_cnt <= wait_cnt - 9'h001;
            end
          end
        end
        agt_data: begin
          if (take) begin
            dw_valid <= 1'b0;
            count <= count + 2'h1;
            if (count == `COB_BLOCK_LAST) begin
              state <= agt_idle;
            end
          end else if (!dw_valid && bus.sys_tick) begin
            // one doubleword per bus cycle at most
            dw_valid <= 1'b1;
            dw_idx <= next_idx;
            dw_data <= line[64*next_idx +: 64];
          end
        end
        default: state <= agt_idle;
      endcase
    end
  end

endmodule : cob_agent

`default_nettype wire

// ===== tb/cob_link_chk.sv
/*
  Checker for the block link between the sequencer end and the agent end.
  Assumes one clock, a synchronous active-high reset, and a free tick.
*/
`timescale 1ns/1ns
`default_nettype none

module cob_link_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // link
  input wire logic sys_tick,
  input wire logic blk_req,
  input wire logic [1:0] blk_start_dw,
  input wire logic blk_subblock,
  input wire logic dw_valid,
  input wire logic dw_ready,
  input wire logic [1:0] doubleword_index,
  input wire logic [63:0] dw_data
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // doublewords taken in the current block
  // ----------------------------------------------------------------
  logic [2:0] taken;
  wire logic take = dw_valid && dw_ready;

  always_ff @(posedge mclk_in) begin
    if (reset_in || !blk_req) begin
      taken <= 3'h0;
    end else if (take) begin
      taken <= taken + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_p_hold: assert property (dw_valid && !dw_ready |=>
    dw_valid && $stable(doubleword_index) && $stable(dw_data)) else $error("word dropped");
  a_p_seq: assert property (dw_valid && !blk_subblock |->
    doubleword_index == taken[1:0]) else $error("sequential order broken");
  a_p_first: assert property (dw_valid && blk_subblock && taken == 3'h0 |->
    doubleword_index == blk_start_dw) else $error("target word not first");
  a_p_xor: assert property (dw_valid && blk_subblock |->
    doubleword_index == (blk_start_dw ^ taken[1:0])) else $error("subblock index wrong");
  a_p_four: assert property (take && taken == 3'h3 |=> !blk_req)
    else $error("block not closed after four words");
  a_p_inblock: assert property (dw_valid |-> blk_req && taken < 3'h4)
    else $error("word outside a block");
  a_p_tick_min: assert property (sys_tick |=> !sys_tick)
    else $error("tick spacing below two");
  a_p_tick_max: assert property (sys_tick |-> ##[2:8] sys_tick)
    else $error("tick spacing above eight");
  a_p_latency: assert property ($rose(blk_req) |-> (!dw_valid) [*8])
    else $error("first word too early");
  a_p_first_bound: assert property ($rose(blk_req) |-> ##[9:600] dw_valid)
    else $error("first word never came");
  a_p_stable: assert property (blk_req ##1 blk_req |->
    $stable(blk_subblock) && $stable(blk_start_dw)) else $error("order changed in block");
endmodule : cob_link_chk

`default_nettype wire

// ===== tb/tb.sv
/*
  Testbench: both ends joined by the link, core ops timed against a model.
  Assumes the design files, package and interface are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  import cob_pkg::*;

  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic op_valid_in = 1'b0, op_secondary_in = 1'b0, op_hit_in = 1'b0, op_subblock_in = 1'b0;
  logic [2:0] op_code_in = 3'h0;
  logic [1:0] op_start_dw_in = 2'h0;
  logic miss_pending_in = 1'b0, writeback_pending_in = 1'b0, ext_req_pending_in = 1'b0;
  logic [3:0] bus_clock_divisor_in = 4'h2;
  logic fill_wr_ready_in = 1'b0, drain_en = 1'b1;
  logic [7:0] memory_latency_cycles_in = 8'h03;
  logic [255:0] fill_line_in = '0;
  logic op_ready_out, op_done_out, cache_modify_out, order_error_out;
  logic fill_wr_valid_out, block_request_out;
  logic [1:0] fill_wr_index_out, block_start_out, cur_st;
  logic [63:0] fill_wr_data_out;
  logic [65:0] drained;
  logic [65:0] exp_q[$];
  logic [31:0] rnd = 32'h35dd, drn = 32'h35dd;
  int errors = 0, compares = 0, cyc = 0, dv = 2, mlv = 3;
  int pcyc[8] = '{7, 7, 8, 1, 7, 0, 7, 1};
  int divs[5] = '{1, 2, 3, 8, 15};

  always #50 mclk_in = ~mclk_in;

  cob_bus_if cob_bus_if_i ();

  cob_sequencer cob_sequencer_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .op_valid_in(op_valid_in), .op_ready_out(op_ready_out), .op_secondary_in(op_secondary_in),
    .op_code_in(op_code_in), .op_hit_in(op_hit_in), .op_start_dw_in(op_start_dw_in),
    .op_subblock_in(op_subblock_in), .op_done_out(op_done_out),
    .cache_modify_out(cache_modify_out), .order_error_out(order_error_out),
    .miss_pending_in(miss_pending_in), .writeback_pending_in(writeback_pending_in),
    .ext_req_pending_in(ext_req_pending_in), .bus_clock_divisor_in(bus_clock_divisor_in),
    .fill_wr_valid_out(fill_wr_valid_out), .fill_wr_ready_in(fill_wr_ready_in),
    .fill_wr_index_out(fill_wr_index_out), .fill_wr_data_out(fill_wr_data_out),
    .bus(cob_bus_if_i));

  cob_agent cob_agent_i (.mclk_in(mclk_in), .reset_in(reset_in), .bus(cob_bus_if_i),
    .memory_latency_cycles_in(memory_latency_cycles_in), .fill_line_in(fill_line_in),
    .block_request_out(block_request_out), .block_start_out(block_start_out));

  cob_link_chk cob_link_chk_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .sys_tick(cob_bus_if_i.sys_tick), .blk_req(cob_bus_if_i.blk_req),
    .blk_start_dw(cob_bus_if_i.blk_start_dw), .blk_subblock(cob_bus_if_i.blk_subblock),
    .dw_valid(cob_bus_if_i.dw_valid), .dw_ready(cob_bus_if_i.dw_ready),
    .doubleword_index(cob_bus_if_i.doubleword_index), .dw_data(cob_bus_if_i.dw_data));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // fifo must be drained first, reset would drop words still expected
  task automatic do_reset();
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 2000) begin
      @(posedge mclk_in);
      k++;
    end
    #1;
    reset_in = 1'b1;
    repeat (16) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
  endtask : do_reset

  task automatic run_op(input logic sec, input logic [2:0] code, input logic hit,
                        input bit timed);
    int lo, hi, p, n, bad, k;
    logic mod;
    k = 0;
    while (op_ready_out !== 1'b1 && k < 3000) begin
      @(posedge mclk_in);
      #1;
      k++;
    end
    p = (code == 3'h1) ? 4 : (code == 3'h5) ? 128 : (code == 3'h0 || code == 3'h2) ? 1 : 0;
    lo = sec ? ((p != 0) ? 6 + p * dv : 1) : (code == 3'h4 && hit) ? 9 :
         (code == 3'h6 && hit) ? 20 : pcyc[code];
    mod = sec ? (p != 0 && code != 3'h1) : (8'h25 >> code) & 1 || (code == 3'h4 && hit);
    if (!sec && code == 3'h5) begin
      rnd = lfsr(rnd);
      cur_st = rnd[1:0];
      op_start_dw_in = rnd[1:0];
      op_subblock_in = rnd[2];
      memory_latency_cycles_in = 8'(rnd[15:8] % 21);
      mlv = (memory_latency_cycles_in < 8'h03) ? 3 : memory_latency_cycles_in;
      lo = 10 + (2 + mlv + 4) * dv;
      for (k = 0; k < 8; k++) begin
        rnd = lfsr(rnd);
        fill_line_in[32*k+:32] = rnd;
      end
      for (k = 0; k < 4; k++) begin
        p = op_subblock_in ? (cur_st ^ k[1:0]) : k;
        exp_q.push_back({p[1:0], fill_line_in[64*p+:64]});
      end
    end
    hi = (sec ? p != 0 : code == 3'h5) ? lo + dv - 1 : lo;
    op_secondary_in = sec;
    op_code_in = code;
    op_hit_in = hit;
    op_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    op_valid_in = 1'b0;
    n = 1;
    bad = 0;
    check(64'(cache_modify_out), 64'(mod));
    while (op_done_out !== 1'b1 && n < 3000) begin
      bad += (op_ready_out !== 1'b0);
      @(posedge mclk_in);
      #1;
      n++;
    end
    bad += (op_ready_out !== 1'b0);
    if (timed) check(64'(n), 64'((n >= lo && n <= hi) ? n : lo));
    check(64'(bad), 64'h0);
    @(posedge mclk_in);
    #1;
    check({op_done_out, op_ready_out}, 64'h1);
  endtask : run_op

  // ----------------------------------------------------------------
  // drain side and monitors
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    #1;
    drn = lfsr(drn);
    fill_wr_ready_in = drain_en && drn[0];
  end

  always @(posedge mclk_in) begin
    if (!reset_in && fill_wr_valid_out === 1'b1 && fill_wr_ready_in === 1'b1) begin
      drained = (exp_q.size() > 0) ? exp_q.pop_front() : 66'h0;
      check(fill_wr_data_out, drained[63:0]);
      check(64'(fill_wr_index_out), 64'(drained[65:64]));
    end
    if (!reset_in && block_request_out === 1'b1) check(64'(block_start_out), 64'(cur_st));
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    op_code_in = 3'h2;
    op_valid_in = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {ext_req_pending_in, writeback_pending_in, miss_pending_in} = 3'(1 << i);
      repeat (12) begin
        @(posedge mclk_in);
        #1;
        check({op_ready_out, op_done_out}, 64'h0);
      end
    end
    op_valid_in = 1'b0;
    {ext_req_pending_in, writeback_pending_in, miss_pending_in} = 3'h0;
    // out-of-range divisors clamp to the nearest end
    for (int d = 0; d < 5; d++) begin
      bus_clock_divisor_in = 4'(divs[d]);
      dv = (divs[d] < 2) ? 2 : (divs[d] > 8) ? 8 : divs[d];
      do_reset();
      for (int s = 0; s < 2; s++)
        for (int c = 0; c < 8; c++)
          for (int h = 0; h < 2; h++)
            run_op(s[0], c[2:0], h[0], 1'b1);
    end
    drain_en = 1'b0;
    run_op(1'b0, 3'h5, 1'b0, 1'b1);
    run_op(1'b0, 3'h5, 1'b0, 1'b1);
    fork
      run_op(1'b0, 3'h5, 1'b0, 1'b0);
      begin
        repeat (300) @(posedge mclk_in);
        #2;
        check({cob_bus_if_i.dw_ready, fill_wr_valid_out}, 64'h1);
        drain_en = 1'b1;
      end
    join
    repeat (200) @(posedge mclk_in);
    #2;
    check(64'(exp_q.size()), 64'h0);
    check({fill_wr_valid_out, order_error_out}, 64'h0);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
